// File: core/spi_strap_master.sv
// Serial flash master with rate strap, suspend and powerdown handling.
// Assumes the user side shares ref_clk; pins are asynchronous to it.
`timescale 1ns/1ns
module spi_strap_master
  import spi_strap_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       reset_pin_n,
  input  wire logic       spi_enable,
  input  wire logic       powerdown,
  input  wire logic       suspend,
  input  wire logic       serial_rate_strap,
  output logic            strap_out,
  output logic            strap_oe_n,
  input  wire logic       serial_data_in,
  output spi_out_t        spi_pins,
  input  wire cmd_t       cmd,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_valid,
  output logic            rate_fast
);

  logic       rpin_s1_q;
  logic       rpin_s2_q;
  logic       strap_s1_q;
  logic       strap_s2_q;
  logic       din_s1_q;
  logic       din_s2_q;
  logic       int_rst;
  logic       strap_valid_q;
  logic       rate_fast_q;
  seq_state_t state_q;
  seq_state_t state_d;
  logic [2:0] half_cnt_q;
  logic [2:0] half_len;
  logic       tick;
  logic [2:0] bit_cnt_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic       hold_q;
  logic       halt;
  logic       take;
  logic       finish;
  spi_out_t   pins_q;
  logic       cmd_ready_q;
  logic       rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic       strap_oe_n_q;
  logic       strap_out_q;

  // Pin synchronisers, two stages each, no reset needed
  always_ff @(posedge ref_clk) begin
    rpin_s1_q  <= reset_pin_n;
    rpin_s2_q  <= rpin_s1_q;
    strap_s1_q <= serial_rate_strap;
    strap_s2_q <= strap_s1_q;
    din_s1_q   <= serial_data_in;
    din_s2_q   <= din_s1_q;
  end

  // Internal reset from either source
  assign int_rst = rst | ~rpin_s2_q;

  // Strap caught on the first edge after reset release, then frozen
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      strap_valid_q <= 1'b0;
      rate_fast_q   <= STRAP_DEFAULT;
    end else if (!strap_valid_q) begin
      strap_valid_q <= 1'b1;
      rate_fast_q   <= strap_s2_q;
    end
  end

  // Strap pin drive: low in suspend only when strapped slow
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      strap_oe_n_q <= 1'b1;
      strap_out_q  <= 1'b0;
    end else begin
      strap_out_q  <= 1'b0;
      if (suspend && strap_valid_q && rate_fast_q == STRAP_SLOW)
        strap_oe_n_q <= 1'b0;
      else
        strap_oe_n_q <= 1'b1;
    end
  end

  // Half period length chosen by the latched strap
  always_comb begin
    if (rate_fast_q == STRAP_FAST)
      half_len = HALF_FAST - 3'h1;
    else
      half_len = HALF_SLOW - 3'h1;
  end

  // Phase tick, stop request and request handshake
  assign tick   = (half_cnt_q == 3'h0);
  assign halt   = powerdown | ~spi_enable;
  assign take   = cmd_valid & cmd_ready_q;
  assign finish = (state_q == S_SHIFT) & tick & pins_q.sclk
                  & (bit_cnt_q == LAST_BIT);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (take)
          state_d = S_SETUP;
      end
      S_SETUP: begin
        if (tick)
          state_d = S_SHIFT;
      end
      S_SHIFT: begin
        if (finish)
          state_d = hold_q ? S_IDLE : S_DESEL;
      end
      S_DESEL: begin
        if (tick)
          state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    if (halt)
      state_d = S_IDLE;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (int_rst)
      state_q <= S_IDLE;
    else
      state_q <= state_d;
  end

  // Half period counter, restarted on every phase change
  always_ff @(posedge ref_clk) begin
    if (int_rst)
      half_cnt_q <= 3'h0;
    else if (take || tick || state_q == S_IDLE)
      half_cnt_q <= half_len;
    else
      half_cnt_q <= half_cnt_q - 3'h1;
  end

  // Request acceptance, only in idle with a settled strap
  always_ff @(posedge ref_clk) begin
    if (int_rst)
      cmd_ready_q <= 1'b0;
    else
      cmd_ready_q <= (state_d == S_IDLE) && !halt && strap_valid_q
                     && !take;
  end

  // Serial pins, shift registers and bit count
  // Data in is read as the clock falls: the two-cycle sync lag then
  // lands the sample no earlier than the rising edge, so halves must be >= 2
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      pins_q    <= '{CE_IDLE, SCLK_IDLE, 1'b0};
      tx_q      <= 8'h00;
      rx_q      <= 8'h00;
      bit_cnt_q <= 3'h0;
      hold_q    <= 1'b0;
    end else if (halt) begin
      pins_q    <= '{CE_IDLE, SCLK_IDLE, 1'b0};
      bit_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (take) begin
            pins_q.chip_enable_n <= 1'b0;
            pins_q.data_out      <= cmd.tx_byte[BYTE_W-1];
            tx_q                 <= {cmd.tx_byte[6:0], 1'b0};
            hold_q               <= cmd.hold_select;
            bit_cnt_q            <= 3'h0;
          end
        end
        S_SHIFT: begin
          if (tick && !pins_q.sclk) begin
            pins_q.sclk <= 1'b1;
          end else if (tick) begin
            pins_q.sclk <= 1'b0;
            rx_q        <= {rx_q[6:0], din_s2_q};
            bit_cnt_q   <= bit_cnt_q + 3'h1;
            if (!finish) begin
              pins_q.data_out <= tx_q[BYTE_W-1];
              tx_q            <= {tx_q[6:0], 1'b0};
            end else if (!hold_q) begin
              pins_q.chip_enable_n <= 1'b1;
            end
          end
        end
        default: begin
          pins_q.sclk <= SCLK_IDLE;
        end
      endcase
    end
  end

  // Received byte, one pulse per finished byte; last bit joins here
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= finish && !halt;
      if (finish && !halt)
        rsp_data_q <= {rx_q[6:0], din_s2_q};
    end
  end

  // Outputs straight from their registers
  assign spi_pins   = pins_q;
  assign cmd_ready  = cmd_ready_q;
  assign rsp_valid  = rsp_valid_q;
  assign rsp_data   = rsp_data_q;
  assign rate_fast  = rate_fast_q;
  assign strap_oe_n = strap_oe_n_q;
  assign strap_out  = strap_out_q;

endmodule

// File: core/spi_strap_pkg.sv
// Constants and carrier types for the serial flash master port.
// Assumes a single 125 MHz reference clock domain for all logic.
package spi_strap_pkg;

  // Clock and serial rates
  localparam int REF_CLK_MHZ   = 125;
  localparam int RATE_SLOW_MHZ = 30;
  localparam int RATE_FAST_MHZ = 60;
  // Half periods of the serial clock, rounded up so the rate never exceeds
  localparam int HALF_SLOW_CYC =
    (REF_CLK_MHZ + 2 * RATE_SLOW_MHZ - 1) / (2 * RATE_SLOW_MHZ);
  localparam int HALF_FAST_CYC =
    (REF_CLK_MHZ + 2 * RATE_FAST_MHZ - 1) / (2 * RATE_FAST_MHZ);
  localparam logic [2:0] HALF_SLOW = 3'(HALF_SLOW_CYC);
  localparam logic [2:0] HALF_FAST = 3'(HALF_FAST_CYC);

  // Least width of the external reset pulse, kept by the far side
  localparam int RST_PULSE_MIN_NS  = 5000;
  localparam int RST_PULSE_MIN_CYC =
    (RST_PULSE_MIN_NS * REF_CLK_MHZ + 999) / 1000;

  // Strap encoding and default through the pull-down
  localparam logic STRAP_SLOW    = 1'b0;
  localparam logic STRAP_FAST    = 1'b1;
  localparam logic STRAP_DEFAULT = STRAP_SLOW;

  // Byte framing
  localparam int         BYTE_W   = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Idle levels of the serial pins
  localparam logic CE_IDLE   = 1'b1;
  localparam logic SCLK_IDLE = 1'b0;

  // One byte to move, with the choice of keeping the slave selected
  typedef struct packed {
    logic [7:0] tx_byte;
    logic       hold_select;
  } cmd_t;

  // Serial outputs towards the slave
  typedef struct packed {
    logic chip_enable_n;
    logic sclk;
    logic data_out;
  } spi_out_t;

  // Transfer sequencer, Gray coded along the usual path
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_SETUP = 2'b01,
    S_SHIFT = 2'b11,
    S_DESEL = 2'b10
  } seq_state_t;

endpackage

// File: sim/spi_strap_master_assertions.sv
// Timing checks on the serial master pins and the strap pin.
// Bound into spi_strap_master; one ref_clk domain.
`timescale 1ns/1ns
module spi_strap_chk
  import spi_strap_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reset_pin_n,
  input wire logic       spi_enable,
  input wire logic       powerdown,
  input wire logic       suspend,
  input wire logic       serial_rate_strap,
  input wire logic       strap_out,
  input wire logic       strap_oe_n,
  input wire logic       serial_data_in,
  input wire spi_out_t   spi_pins,
  input wire cmd_t       cmd,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rate_fast
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pin behaviour per state
  AST_CE_PWRDN:
    assert property ((spi_enable && powerdown) [*3]
      |-> spi_pins.chip_enable_n) else $error("select in powerdown");
  AST_STRAP_LOW:
    assert property (suspend && !rate_fast |=> !strap_oe_n && !strap_out)
    else $error("strap pin not driven low");
  AST_STRAP_TRI:
    assert property (suspend && rate_fast |=> strap_oe_n)
    else $error("strap pin not released");
  AST_HALF_FAST:
    assert property ($rose(spi_pins.sclk) && rate_fast
      |-> spi_pins.sclk [*2] ##1 !spi_pins.sclk) else $error("fast half");
  AST_HALF_SLOW:
    assert property ($rose(spi_pins.sclk) && !rate_fast
      |-> spi_pins.sclk [*3] ##1 !spi_pins.sclk) else $error("slow half");
  AST_SCLK_CE:
    assert property (spi_pins.sclk |-> !spi_pins.chip_enable_n)
    else $error("clock without select");
  AST_TAKE:
    assert property (cmd_valid && cmd_ready
      |=> !cmd_ready && !spi_pins.chip_enable_n) else $error("no select");
  AST_RSP:
    assert property (cmd_valid && cmd_ready && rate_fast
      |-> ##[30:40] rsp_valid) else $error("late byte");
  AST_PIN_RST:
    assert property (!reset_pin_n [*4] |-> !cmd_ready
      && spi_pins.chip_enable_n) else $error("pin reset ignored");
endmodule
bind spi_strap_master spi_strap_chk chk_u (
  .ref_clk           (ref_clk),
  .rst               (rst),
  .reset_pin_n       (reset_pin_n),
  .spi_enable        (spi_enable),
  .powerdown         (powerdown),
  .suspend           (suspend),
  .serial_rate_strap (serial_rate_strap),
  .strap_out         (strap_out),
  .strap_oe_n        (strap_oe_n),
  .serial_data_in    (serial_data_in),
  .spi_pins          (spi_pins),
  .cmd               (cmd),
  .cmd_valid         (cmd_valid),
  .cmd_ready         (cmd_ready),
  .rsp_data          (rsp_data),
  .rsp_valid         (rsp_valid),
  .rate_fast         (rate_fast)
);

// File: sim/flash_model.sv
// Serial flash stand-in: returns one reply byte per byte moved.
// Data line has a pull-down, so it reads low when deselected.
`timescale 1ns/1ns
module flash_model
  import spi_strap_pkg::*;
(
  input wire spi_out_t   pins,
  input wire logic [7:0] reply,
  output logic           miso,
  output logic [7:0]     rx
);
  logic [2:0] cnt = 3'h0;
  // Bit count within a byte, cleared on deselect
  always @(negedge pins.sclk or posedge pins.chip_enable_n)
    if (pins.chip_enable_n) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  // Capture master data on the rising clock
  always @(posedge pins.sclk) rx <= {rx[6:0], pins.data_out};
  // Reply MSB first while selected
  assign miso = pins.chip_enable_n ? 1'b0 : reply[3'h7 - cnt];
endmodule

// File: sim/tb.sv
// Self-checking bench for spi_strap_master with a flash stand-in.
// Inputs change on the falling clock edge.
`timescale 1ns/1ns
module tb;
  import spi_strap_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1;
  logic spi_enable = 1'b1, powerdown = 1'b0, suspend = 1'b0;
  logic serial_rate_strap = 1'b0, cmd_valid = 1'b0;
  logic strap_out, strap_oe_n, serial_data_in, cmd_ready;
  logic rsp_valid, rate_fast;
  logic [7:0] rsp_data, rx, reply = 8'h00;
  logic [15:0] e;
  logic [15:0] q[$];
  spi_out_t spi_pins;
  cmd_t cmd = '0;
  int failures = 0, compares = 0;
  // Applied clock matches the frequency the design is set for
  always #(500 / REF_CLK_MHZ) ref_clk = ~ref_clk;
  spi_strap_master dut_u (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .reset_pin_n       (reset_pin_n),
    .spi_enable        (spi_enable),
    .powerdown         (powerdown),
    .suspend           (suspend),
    .serial_rate_strap (serial_rate_strap),
    .strap_out         (strap_out),
    .strap_oe_n        (strap_oe_n),
    .serial_data_in    (serial_data_in),
    .spi_pins          (spi_pins),
    .cmd               (cmd),
    .cmd_valid         (cmd_valid),
    .cmd_ready         (cmd_ready),
    .rsp_data          (rsp_data),
    .rsp_valid         (rsp_valid),
    .rate_fast         (rate_fast)
  );
  flash_model flash_u (.pins(spi_pins), .reply(reply),
    .miso(serial_data_in), .rx(rx));
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One bounded wait step
  task automatic tick(inout int n);
    cyc(1);
    if (++n > 300) begin
      failures++;
      $display("Error wait_limit expected %0d seen %0d", 300, n);
      wrap_up();
    end
  endtask
  // Hold the request until taken; note the expected bytes
  task automatic send(input logic [7:0] tx, input logic hold);
    int n = 0;
    @(negedge ref_clk);
    cmd = '{tx, hold};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) tick(n);
    q.push_back({reply, tx});
    cyc(1);
    cmd_valid = 1'b0;
  endtask
  task automatic drain;
    int n = 0;
    while (q.size() > 0 || cmd_ready !== 1'b1) tick(n);
  endtask
  task automatic do_reset(input logic s);
    serial_rate_strap = s;
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    cyc(3);
    chk("rate_fast", {7'h0, s}, {7'h0, rate_fast});
  endtask
  task automatic probe(input logic s, exp);
    suspend = s;
    cyc(2);
    chk("strap_oe_n", {7'h0, exp}, {7'h0, strap_oe_n});
    chk("strap_out", 8'h00, {7'h0, strap_out});
    suspend = 1'b0;
    cyc(1);
  endtask
  // Response watcher
  always @(negedge ref_clk)
    if (rsp_valid === 1'b1 && q.size() == 0) begin
      chk("rsp_count", 8'h00, 8'h01);
    end else if (rsp_valid === 1'b1) begin
      e = q.pop_front();
      chk("rsp_data", e[15:8], rsp_data);
      chk("mosi_byte", e[7:0], rx);
    end
  initial begin
    void'($urandom(32'hAAEA1010));
    do_reset(1'b0);
    reply = 8'($urandom);
    send(8'($urandom), 1'b0);
    drain();
    serial_rate_strap = 1'b1;
    send(8'($urandom), 1'b0);
    drain();
    chk("rate_fast", 8'h00, {7'h0, rate_fast});
    chk("ce_n", 8'h01, {7'h0, spi_pins.chip_enable_n});
    probe(1'b1, 1'b0);
    do_reset(1'b1);
    probe(1'b1, 1'b1);
    probe(1'b0, 1'b1);
    reply = 8'($urandom);
    send(8'($urandom), 1'b1);
    send(8'($urandom), 1'b0);
    drain();
    send(8'($urandom), 1'b1);
    drain();
    chk("ce_n", 8'h00, {7'h0, spi_pins.chip_enable_n});
    powerdown = 1'b1;
    cyc(3);
    chk("ce_n", 8'h01, {7'h0, spi_pins.chip_enable_n});
    chk("cmd_ready", 8'h00, {7'h0, cmd_ready});
    powerdown = 1'b0;
    spi_enable = 1'b0;
    cyc(3);
    chk("cmd_ready", 8'h00, {7'h0, cmd_ready});
    spi_enable = 1'b1;
    reset_pin_n = 1'b0;
    cyc(RST_PULSE_MIN_CYC);
    chk("cmd_ready", 8'h00, {7'h0, cmd_ready});
    reset_pin_n = 1'b1;
    drain();
    chk("rate_fast", 8'h01, {7'h0, rate_fast});
    wrap_up();
  end
endmodule
